// ### pkg/cmb_pkg.sv
// Purpose: shared constants and state types of the csr mux bus
// Assumes: both ends run on one 100 MHz master clock
// Notes: bank select field, bank ranges and read latency live here
package cmb_pkg;
  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int AW = 16;
  localparam int RW = 5;
  localparam int NBANK = 5;
  localparam int COM_IDX = 4;
  localparam int BURST_BIT = 15;
  localparam int SEL_LO = 10;
  localparam int STOP_LO = 5;
  localparam int START_LO = 0;
  localparam logic [RW-1:0] CHAN_TOP = 5'h18;
  localparam logic [RW-1:0] COMMON_BASE = 5'h19;
  localparam logic [RW-1:0] REG_TOP = 5'h1F;
  // ----------------------------------------------------------------
  // timing in master clock cycles
  // ----------------------------------------------------------------
  localparam logic [7:0] FIRST_WORD = 8'h04;
  localparam logic [7:0] GAP_SINGLE = 8'h01;
  localparam logic [7:0] GAP_BURST = 8'h02;
  // ----------------------------------------------------------------
  // host command registers
  // ----------------------------------------------------------------
  localparam logic [7:0] HR_CMD = 8'h00;
  localparam logic [7:0] HR_STAT = 8'h04;
  localparam int HR_DATA_BIT = 7;
  localparam int CMD_RD = 16;
  localparam int CMD_HOLD = 17;
  localparam int CMD_LEN_LO = 24;
  localparam int LEN_W = 5;
  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    CMB_IDLE = 5'h01,
    CMB_WDATA = 5'h02,
    CMB_RTURN = 5'h04,
    CMB_RPRE = 5'h08,
    CMB_RDATA = 5'h10
  } cmb_dst_e;
  typedef enum logic [1:0] {
    CMB_HIDLE = 2'h1,
    CMB_HRUN = 2'h2
  } cmb_hst_e;
endpackage

// ### pkg/cmb_if.sv
// Purpose: shared bus between host and device ends
// Assumes: one master clock for both ends
// Notes: undriven address/data reads as zero; clash flags double drive
`timescale 1ns/100ps
`default_nettype none
interface cmb_if import cmb_pkg::*;;
  logic [AW-1:0] ad_h;
  logic ad_h_oe;
  logic [AW-1:0] ad_d;
  logic ad_d_oe;
  logic strobe;
  logic rd;
  logic [AW-1:0] ad;
  logic clash;
  // resolve the shared lines from the two enables
  assign ad = ad_d_oe ? ad_d : (ad_h_oe ? ad_h : 16'h0000);
  assign clash = ad_d_oe & ad_h_oe;
  modport dev (input ad, strobe, rd, output ad_d, ad_d_oe);
  modport host (input ad, output ad_h, ad_h_oe, strobe, rd);
endinterface
`default_nettype wire

// ### rtl/cmb_bank.sv
// Purpose: one register bank of 32 words
// Assumes: writes come from the re-registered write stage
// Notes: only addresses inside lo..hi exist; others read zero
`timescale 1ns/100ps
`default_nettype none
module cmb_bank import cmb_pkg::*; #(
  parameter logic [RW-1:0] LO = 5'h00,
  parameter logic [RW-1:0] HI = 5'h18
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // write port
  input wire logic we_i,
  input wire logic wsel_i,
  input wire logic [RW-1:0] waddr_i,
  input wire logic [AW-1:0] wdata_i,
  // read port
  input wire logic rsel_i,
  input wire logic [RW-1:0] raddr_i,
  output logic [AW-1:0] rdata_o
);
  typedef struct packed {
    logic [(1<<RW)-1:0][AW-1:0] mem;
  } cmb_bank_s;
  cmb_bank_s s;
  cmb_bank_s next_s;
  // single-cycle store when selected and in range
  always_comb begin
    next_s = s;
    if (we_i && wsel_i && waddr_i >= LO && waddr_i <= HI) begin
      next_s.mem[waddr_i] = wdata_i;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  // unselected bank adds zero to the OR
  assign rdata_o = (rsel_i && raddr_i >= LO && raddr_i <= HI) ? s.mem[raddr_i] : '0;
endmodule
`default_nettype wire

// ### rtl/cmb_dev.sv
// Purpose: device end of the muxed csr bus with five banks
// Assumes: host keeps the spacing and direction rules
// Notes: read data appears four cycles after the address cycle
//
// Decided for this implementation: the address map and the internal write bus to the register banks.
`timescale 1ns/100ps
`default_nettype none
module cmb_dev import cmb_pkg::*; #(
  parameter int LW = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // shared bus
  cmb_if.dev bus,
  // internal write bus seen by the banks
  output logic wr_en_o,
  output logic [NBANK-1:0] wr_sel_o,
  output logic [RW-1:0] wr_addr_o,
  output logic [AW-1:0] wr_data_o,
  // status
  output logic busy_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    cmb_dst_e st;
    logic strobe_q;
    logic rd_q;
    logic [AW-1:0] ad_q;
    logic burst;
    logic [NBANK-1:0] sel;
    logic [RW-1:0] start;
    logic [RW-1:0] stop;
    logic [RW-1:0] addr;
    logic hold;
    logic phase;
    logic open;
    logic [LW-1:0] left;
    logic [AW-1:0] ad;
    logic oe;
    logic wen;
    logic [NBANK-1:0] wsel;
    logic [RW-1:0] waddr;
    logic [AW-1:0] wdata;
    logic busy;
  } cmb_dev_s;

  cmb_dev_s s;
  cmb_dev_s next_s;
  logic [NBANK-1:0][AW-1:0] rdat;
  logic [AW-1:0] rd_or;
  logic [RW-1:0] nxt;
  logic [LW-1:0] avail;
  logic rdst;

  // ----------------------------------------------------------------
  // register banks: four channels and the common bank
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NBANK; i++) begin : g_bank
    cmb_bank #(
      .LO(i == COM_IDX ? COMMON_BASE : 5'h00),
      .HI(i == COM_IDX ? REG_TOP : CHAN_TOP)
    ) u_bank (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(s.wen),
      .wsel_i(s.wsel[i]),
      .waddr_i(s.waddr),
      .wdata_i(s.wdata),
      .rsel_i(s.sel[i]),
      .raddr_i(s.addr),
      .rdata_o(rdat[i])
    );
  end

  // ----------------------------------------------------------------
  // read merge and address stepping
  // ----------------------------------------------------------------
  // merge every bank contribution
  always_comb begin
    rd_or = '0;
    for (int b = 0; b < NBANK; b++) begin
      rd_or = rd_or | rdat[b];
    end
  end

  // single access keeps its address, burst walks and wraps
  always_comb begin
    if (!s.burst) begin
      nxt = s.addr;
    end else if (s.addr == s.stop) begin
      nxt = s.start;
    end else begin
      nxt = s.addr + 5'h01;
    end
  end

  // read data cycles seen but not yet answered with a word, counted only while reading
  assign rdst = (s.st == CMB_RTURN) || (s.st == CMB_RPRE) || (s.st == CMB_RDATA);
  assign avail = s.left + LW'(s.open);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    // every pin is caught on the rising clock before use
    next_s.strobe_q = bus.strobe;
    next_s.rd_q = bus.rd;
    next_s.ad_q = bus.ad;
    next_s.wen = 1'b0;

    // count host data cycles of a read; strobe low closes it
    if (rdst) begin
      next_s.left = avail;
      if (s.open) begin
        next_s.open = s.strobe_q;
      end
    end

    case (s.st)
      CMB_IDLE: begin
        next_s.oe = 1'b0;
        if (s.strobe_q) begin
          // split the address word into its fields
          next_s.burst = s.ad_q[BURST_BIT];
          next_s.sel = s.ad_q[SEL_LO +: NBANK];
          next_s.stop = s.ad_q[STOP_LO +: RW];
          next_s.start = s.ad_q[START_LO +: RW];
          next_s.addr = s.ad_q[START_LO +: RW];
          next_s.open = 1'b1;
          next_s.left = '0;
          next_s.phase = 1'b0;
          next_s.hold = 1'b0;
          // direction is fixed by the address cycle
          if (s.rd_q) begin
            next_s.st = CMB_RTURN;
          end else begin
            next_s.st = CMB_WDATA;
          end
        end
      end

      CMB_WDATA: begin
        // retime the word so the bank store takes one cycle
        next_s.wen = |s.sel;
        next_s.wsel = s.sel;
        next_s.waddr = s.addr;
        next_s.wdata = s.ad_q;
        next_s.addr = nxt;
        // strobe low marks the last data cycle; next word may be an address
        if (!s.strobe_q) begin
          next_s.st = CMB_IDLE;
        end
      end

      CMB_RTURN: begin
        // bus left undriven this cycle; hold request sampled here
        next_s.hold = s.rd_q;
        next_s.oe = 1'b1;
        next_s.ad = '0;
        next_s.st = CMB_RPRE;
      end

      CMB_RPRE: begin
        // precharge cycle, then first word
        next_s.ad = rd_or;
        next_s.addr = nxt;
        next_s.left = avail - LW'(1);
        next_s.phase = 1'b0;
        next_s.st = CMB_RDATA;
      end

      CMB_RDATA: begin
        if (s.hold && !s.phase) begin
          // keep the word a second cycle
          next_s.phase = 1'b1;
        end else if (avail != '0) begin
          next_s.ad = rd_or;
          next_s.addr = nxt;
          next_s.left = avail - LW'(1);
          next_s.phase = 1'b0;
        end else begin
          // release on the clock after the last word
          next_s.oe = 1'b0;
          next_s.ad = '0;
          next_s.st = CMB_IDLE;
        end
      end

      default: begin
        next_s.st = CMB_IDLE;
        next_s.oe = 1'b0;
      end
    endcase

    next_s.busy = (next_s.st != CMB_IDLE);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
      s.st <= CMB_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  // bus drive
  assign bus.ad_d = s.ad;
  assign bus.ad_d_oe = s.oe;
  // internal write bus and status
  assign wr_en_o = s.wen;
  assign wr_sel_o = s.wsel;
  assign wr_addr_o = s.waddr;
  assign wr_data_o = s.wdata;
  assign busy_o = s.busy;
endmodule
`default_nettype wire

// ### rtl/cmb_host.sv
// Purpose: host end, runs bus transactions ordered over wishbone
// Assumes: classic wishbone master on the software side
// Notes: data words for bursts live in a local 32-word store
`timescale 1ns/100ps
`default_nettype none
module cmb_host import cmb_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // shared bus
  cmb_if.host bus
);
  typedef struct packed {
    cmb_hst_e st;
    logic [31:0] cmd;
    logic [31:0] pcmd;
    logic pend;
    logic [7:0] t;
    logic [AW-1:0] ad;
    logic oe;
    logic strobe;
    logic rd;
    logic ack;
    logic [31:0] dat;
    logic [(1<<LEN_W)-1:0][AW-1:0] mem;
  } cmb_host_s;
  cmb_host_s s;
  cmb_host_s next_s;
  logic [5:0] len;
  logic [7:0] lm1, last, fin, nt, k, widx;
  logic rdcmd, hold, launch;
  logic [31:0] cmdw, lcmd;

  // transaction shape from the running command
  always_comb begin
    rdcmd = s.cmd[CMD_RD];
    hold = s.cmd[CMD_HOLD];
    len = s.cmd[BURST_BIT] ? {1'b0, s.cmd[CMD_LEN_LO +: LEN_W]} + 6'h01 : 6'h01;
    lm1 = {2'b00, len} - 8'h01;
    // last cycle the device drives read data; a held word stands two cycles
    last = FIRST_WORD + (hold ? {lm1[6:0], 1'b1} : lm1);
    fin = rdcmd ? last + (s.cmd[BURST_BIT] ? GAP_BURST : GAP_SINGLE) : {2'b00, len};
    nt = s.t + 8'h01;
    k = s.t - FIRST_WORD;
    widx = hold ? {1'b0, k[7:1]} : k;
  end

  always_comb begin
    next_s = s;
    launch = 1'b0;
    lcmd = s.pcmd;
    cmdw = s.cmd;
    next_s.ack = wb_cyc_i && wb_stb_i && !s.ack;
    // wishbone decode, one access per ack
    if (wb_cyc_i && wb_stb_i && !s.ack) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          cmdw[b*8 +: 8] = wb_dat_i[b*8 +: 8];
        end
      end
      if (wb_adr_i == HR_CMD) begin
        next_s.dat = s.cmd;
        if (wb_we_i && !s.pend) begin
          if (s.st == CMB_HIDLE) begin
            launch = 1'b1;
            lcmd = cmdw;
          end else begin
            next_s.pend = 1'b1; // queued for back to back
            next_s.pcmd = cmdw;
          end
        end
      end else if (wb_adr_i == HR_STAT) begin
        next_s.dat = {30'h00000000, s.pend, s.st == CMB_HRUN};
      end else if (wb_adr_i[HR_DATA_BIT]) begin
        next_s.dat = {16'h0000, s.mem[wb_adr_i[6:2]]};
        if (wb_we_i && wb_sel_i[0]) begin
          next_s.mem[wb_adr_i[6:2]][7:0] = wb_dat_i[7:0];
        end
        if (wb_we_i && wb_sel_i[1]) begin
          next_s.mem[wb_adr_i[6:2]][15:8] = wb_dat_i[15:8];
        end
      end else begin
        next_s.dat = 32'h00000000;
      end
    end
    case (s.st)
      CMB_HRUN: begin
        // capture read words at their fixed slots
        if (rdcmd && s.t >= FIRST_WORD && (!hold || !k[0]) && widx < {2'b00, len}) begin
          next_s.mem[widx[LEN_W-1:0]] = bus.ad;
        end
        if (s.t == fin) begin
          if (s.pend) begin
            launch = 1'b1;
            next_s.pend = 1'b0;
          end else begin
            next_s.st = CMB_HIDLE;
            next_s.oe = 1'b0;
            next_s.strobe = 1'b0;
            next_s.rd = 1'b0;
          end
        end else begin
          next_s.t = nt;
          next_s.strobe = nt < {2'b00, len};
          next_s.oe = !rdcmd && nt <= {2'b00, len};
          next_s.ad = s.mem[lm1[LEN_W-1:0] - lm1[LEN_W-1:0] + s.t[LEN_W-1:0]];
          next_s.rd = rdcmd && hold && nt <= {2'b00, len};
        end
      end
      default: begin
        next_s.st = CMB_HIDLE;
        // an order queued on the very last cycle starts from idle
        if (s.pend) begin
          launch = 1'b1;
          next_s.pend = 1'b0;
        end
      end
    endcase
    // address cycle of a new transaction
    if (launch) begin
      next_s.st = CMB_HRUN;
      next_s.cmd = lcmd;
      next_s.t = 8'h00;
      next_s.ad = lcmd[AW-1:0];
      next_s.oe = 1'b1;
      next_s.strobe = 1'b1;
      next_s.rd = lcmd[CMD_RD];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
      s.st <= CMB_HIDLE;
    end else begin
      s <= next_s;
    end
  end

  // outputs from flops
  assign bus.ad_h = s.ad;
  assign bus.ad_h_oe = s.oe;
  assign bus.strobe = s.strobe;
  assign bus.rd = s.rd;
  assign wb_dat_o = s.dat;
  assign wb_ack_o = s.ack;
endmodule
`default_nettype wire

// ### dv/cmb_asserts.sv
// Purpose: timing checks on the shared csr bus between host and device
// Assumes: one master clock, rst_i asynchronous and active high
// Notes: t=0 is the address cycle; read words start at t=4
`timescale 1ns/100ps
`default_nettype none
module cmb_asserts import cmb_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // shared bus
  input wire logic [AW-1:0] ad_h,
  input wire logic ad_h_oe,
  input wire logic [AW-1:0] ad_d,
  input wire logic ad_d_oe,
  input wire logic strobe,
  input wire logic rd,
  input wire logic [AW-1:0] ad,
  input wire logic clash
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  // read address cycle driven by the host
  sequence rd_addr_s;
    $rose(strobe) && rd && ad_h_oe;
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  no_clash_a: assert property (!clash)
    else $error("both ends drive the bus");
  addr_first_a: assert property ($rose(strobe) |-> ad_h_oe && !ad_d_oe)
    else $error("address cycle not driven by host");
  read_turn_a: assert property (rd_addr_s |-> ##1 !ad_h_oe ##1 !ad_d_oe ##1 (ad_d_oe && ad == 16'h0000))
    else $error("read turnaround or precharge wrong");
  write_data_a: assert property ($rose(strobe) && !rd |-> ##1 (ad_h_oe && !ad_d_oe))
    else $error("write data cycle not driven by host");
  release_gap_a: assert property ($fell(ad_d_oe) |-> !ad_h_oe && !strobe)
    else $error("host drives as device releases");
  single_len_a: assert property ((rd_addr_s and !ad[15]) ##1 !rd |-> ##2 ad_d_oe [*2] ##1 !ad_d_oe)
    else $error("single read drive length wrong");
  hold_len_a: assert property ((rd_addr_s and !ad[15]) ##1 rd |-> ##2 ad_d_oe [*3] ##1 !ad_d_oe)
    else $error("held read drive length wrong");
  burst_end_a: assert property ($fell(strobe) && ad_h_oe |-> ##1 (!ad_h_oe || strobe))
    else $error("data sent after strobe dropped");
  // main scenarios seen
  cover property (rd_addr_s and ad[15]);
  cover property ($rose(strobe) && !rd && ad_h[15]);
  cover property (rd_addr_s ##1 rd);
endmodule
`default_nettype wire

// ### dv/cmb_tb.sv
// Purpose: drives the host over wishbone and checks what the banks hold
// Assumes: one 100 MHz clock, reset held 10 cycles
// Notes: expectations are worked out from the address word rules
`timescale 1ns/100ps
`default_nettype none
module cmb_tb import cmb_pkg::*;;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0, wb_q, q;
  logic wr_en, busy;
  logic [NBANK-1:0] wr_sel, last_sel;
  logic [RW-1:0] wr_addr, last_addr;
  logic [AW-1:0] wr_data, last_data;
  int n_fail = 0, cmp_count = 0, n_wr = 0, n0;
  cmb_if bus_if();
  // clock
  always #5 clk_i = ~clk_i;
  // ----------------------------------------------------------------
  // design and checker
  // ----------------------------------------------------------------
  cmb_host i_cmb_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack), .bus(bus_if.host));
  cmb_dev i_cmb_dev (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if.dev), .wr_en_o(wr_en), .wr_sel_o(wr_sel),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data), .busy_o(busy));
  cmb_asserts i_cmb_asserts (.clk_i(clk_i), .rst_i(rst_i), .ad_h(bus_if.ad_h), .ad_h_oe(bus_if.ad_h_oe),
    .ad_d(bus_if.ad_d), .ad_d_oe(bus_if.ad_d_oe), .strobe(bus_if.strobe), .rd(bus_if.rd), .ad(bus_if.ad),
    .clash(bus_if.clash));
  // count internal bank writes and keep the last target
  always @(posedge clk_i) begin
    if (wr_en === 1'b1) begin
      n_wr++;
      {last_sel, last_addr, last_data} <= {wr_sel, wr_addr, wr_data};
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // one classic wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    r = wb_q;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // order a transfer and poll until the host is idle
  task automatic run(input logic [31:0] cmd);
    int n = 0;
    wb(1'b1, HR_CMD, cmd, q);
    do begin
      wb(1'b0, HR_STAT, 32'h0, q);
      n++;
    end while (q[1:0] !== 2'b00 && n < 100);
    if (n >= 100) n_fail++;
    // the device stores the last word two cycles after the host goes idle
    repeat (4) @(posedge clk_i);
  endtask
  function automatic logic [31:0] cmd(logic [4:0] len1, logic hold, logic r, logic b, logic [4:0] s,
    logic [4:0] stp, logic [4:0] st);
    return {3'h0, len1, 6'h00, hold, r, b, s, stp, st};
  endfunction
  task automatic setd(input int k, input logic [15:0] d);
    wb(1'b1, 8'h80 + 8'(4 * k), {16'h0, d}, q);
  endtask
  task automatic getd(input int k, input logic [15:0] e);
    wb(1'b0, 8'h80 + 8'(4 * k), 32'h0, q);
    chk("data word", {16'h0, e}, {16'h0, q[15:0]});
  endtask
  // single write with a nonzero stop field that must be ignored
  task automatic wr1(input logic [4:0] s, input logic [4:0] a, input logic [15:0] d);
    setd(0, d);
    run(cmd(5'h00, 1'b0, 1'b0, 1'b0, s, 5'h15, a));
  endtask
  task automatic rd1(input logic [4:0] s, input logic [4:0] a, input logic h, input logic [15:0] e);
    setd(0, 16'h5A5A);
    run(cmd(5'h00, h, 1'b1, 1'b0, s, 5'h15, a));
    getd(0, e);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // watchdog: tests need well under 20000 cycles
  // ----------------------------------------------------------------
  initial begin
    #200000;
    n_fail++;
    tally_and_finish;
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    n0 = n_wr;
    wr1(5'h01, 5'h03, 16'h1234);
    chk("write count", 1, n_wr - n0);
    chk("write bank", 5'h01, last_sel);
    chk("write reg", 5'h03, last_addr);
    chk("write data", 16'h1234, last_data);
    chk("device idle", 0, busy);
    rd1(5'h01, 5'h03, 1'b0, 16'h1234);
    $display("single access test done");
    wr1(5'h06, 5'h05, 16'h00F0);
    chk("multi bank", 5'h06, last_sel);
    wr1(5'h08, 5'h05, 16'h0F01);
    rd1(5'h0A, 5'h05, 1'b1, 16'h0FF1);
    rd1(5'h04, 5'h05, 1'b0, 16'h00F0);
    $display("multi bank test done");
    wr1(5'h10, 5'h19, 16'hA5A5);
    chk("common bank", 5'h10, last_sel);
    rd1(5'h10, 5'h19, 1'b0, 16'hA5A5);
    rd1(5'h01, 5'h19, 1'b0, 16'h0000);
    n0 = n_wr;
    wr1(5'h00, 5'h03, 16'hFFFF);
    chk("no bank write", 0, n_wr - n0);
    rd1(5'h01, 5'h03, 1'b0, 16'h1234);
    rd1(5'h00, 5'h03, 1'b0, 16'h0000);
    $display("bank select test done");
    // burst of four wraps from 0x0A back to 0x08
    for (int k = 0; k < 4; k++) setd(k, 16'hB000 + 16'(k));
    n0 = n_wr;
    run(cmd(5'h03, 1'b0, 1'b0, 1'b1, 5'h01, 5'h0A, 5'h08));
    chk("burst writes", 4, n_wr - n0);
    chk("burst wrap", 5'h08, last_addr);
    for (int h = 0; h < 2; h++) begin
      for (int k = 0; k < 4; k++) setd(k, 16'h0000);
      run(cmd(5'h03, h[0], 1'b1, 1'b1, 5'h01, 5'h0A, 5'h08));
      getd(0, 16'hB003);
      getd(1, 16'hB001);
      getd(2, 16'hB002);
      getd(3, 16'hB003);
    end
    $display("burst test done");
    // back to back: a burst keeps the host busy, so a write and a read queue behind it
    for (int k = 0; k < 4; k++) setd(k, 16'h0770 + 16'(k));
    n0 = n_wr;
    wb(1'b1, HR_CMD, cmd(5'h03, 1'b0, 1'b0, 1'b1, 5'h01, 5'h04, 5'h01), q);
    wb(1'b1, HR_CMD, cmd(5'h00, 1'b0, 1'b0, 1'b0, 5'h01, 5'h00, 5'h06), q);
    run(cmd(5'h00, 1'b0, 1'b1, 1'b0, 5'h01, 5'h00, 5'h02));
    chk("back to back", 5, n_wr - n0);
    getd(0, 16'h0771);
    rd1(5'h01, 5'h06, 1'b0, 16'h0770);
    wb(1'b0, 8'h40, 32'h0, q);
    chk("unmapped", 32'h0, q);
    $display("back to back test done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
